// File: logic/mrs_crc.sv
`timescale 1ns/1ps
module mrs_crc (
	input wire logic i_clk,
	input wire logic i_arst_n,
	mrs_crc_if.core crc_port
);
	// ----------------------------------------
	// reflected crc-16, one byte per cycle
	// ----------------------------------------
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ mrs_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			crc_port.crc <= mrs_pkg::CRC_INIT;
		end else if (crc_port.clear) begin
			crc_port.crc <= mrs_pkg::CRC_INIT;
		end else if (crc_port.valid) begin
			crc_port.crc <= crc_byte(crc_port.crc, crc_port.data);
		end
	end
endmodule

// File: logic/mrs_crc_if.sv
`timescale 1ns/1ps
interface mrs_crc_if;
	logic clear;
	logic valid;
	logic [7:0] data;
	logic [15:0] crc;

	modport core (
		input clear,
		input valid,
		input data,
		output crc
	);
	modport user (
		output clear,
		output valid,
		output data,
		input crc
	);
endinterface

// File: logic/mrs_hold.sv
`timescale 1ns/1ps
module mrs_hold #(
	parameter int HOLD_CYCLES = mrs_pkg::HOLD_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_active,
	output logic o_held
);
	logic [mrs_pkg::HOLD_W-1:0] left;

	// ----------------------------------------
	// stretch an active level by the hold time
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			left <= '0;
			o_held <= 1'b0;
		end else if (i_active) begin
			left <= HOLD_CYCLES[mrs_pkg::HOLD_W-1:0];
			o_held <= 1'b1;
		end else if (left != '0) begin
			left <= left - 1'b1;
			o_held <= 1'b1;
		end else begin
			o_held <= 1'b0;
		end
	end
endmodule

// File: logic/mrs_pkg.sv
package mrs_pkg;
	// function codes and exception answers
	localparam logic [7:0] FN_COILS = 8'h01;
	localparam logic [7:0] FN_DISC = 8'h02;
	localparam logic [7:0] FN_HOLD = 8'h03;
	localparam logic [7:0] FN_INPUT = 8'h04;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [7:0] ADDR_BCAST = 8'h00;

	// frame shape
	localparam logic [7:0] REQ_LEN = 8'h08;
	localparam logic [7:0] MIN_LEN = 8'h04;
	localparam logic [7:0] EXC_LEN = 8'h05;
	localparam logic [7:0] HDR_LEN = 8'h03;
	localparam logic [7:0] CRC_LEN = 8'h02;

	// crc
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	// address map limits
	localparam logic [16:0] COIL_COUNT = 17'h00003;
	localparam logic [16:0] DISC_COUNT = 17'h00022;
	localparam logic [16:0] INPUT_COUNT = 17'h0000a;
	localparam logic [16:0] HOLD_BASE = 17'h0c354;
	localparam logic [16:0] HOLD_COUNT = 17'h00002;
	localparam logic [16:0] MAX_BITS = 17'h007d0;
	localparam logic [16:0] MAX_REGS = 17'h0007d;

	// input register offsets
	localparam logic [3:0] REG_TOTAL_SHOTS_LOW = 4'h0;
	localparam logic [3:0] REG_TOTAL_SHOTS_HIGH = 4'h1;
	localparam logic [3:0] REG_FAILED_SHOTS_LOW = 4'h2;
	localparam logic [3:0] REG_FAILED_SHOTS_HIGH = 4'h3;
	localparam logic [3:0] REG_RUN_START_DATE = 4'h4;
	localparam logic [3:0] REG_RUN_START_CLOCK = 4'h6;
	localparam logic [3:0] REG_INTERVAL_SECONDS_LOW = 4'h8;
	localparam logic [3:0] REG_INTERVAL_SECONDS_HIGH = 4'h9;

	// bit positions
	localparam int COIL_START = 0;
	localparam int COIL_CLEAR = 1;
	localparam int COIL_HALT = 2;
	localparam int DISC_SHOT = 32;
	localparam int DISC_ERROR = 33;
	localparam logic [7:0] BIT_SPAN = 8'h28;

	// timing
	localparam int CLK_HZ = 125000000;
	localparam int HOLD_TIME_MS = 1000;
	localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_TIME_MS;
	localparam int HOLD_W = 27;

	typedef enum logic [2:0] {
		ST_RX = 3'b001,
		ST_EVAL = 3'b010,
		ST_SEND = 3'b100
	} mrs_state_t;
endpackage

// File: logic/mrs_slave.sv
// What this block does
// [R1] host request: addr, func, start, quantity, crc
// [R2] reply echoes addr, func, count, big-endian data
// [R3] regs 0-3: total and failed shot counts
// [R4] errors return func plus 0x80, code
// [R5] crc-16 appended to every sent frame
// [R6] receiver recomputes crc, rejects on mismatch
// [R7] crc sent low byte first
// [R8] coil 0: start, low held one second
// [R9] coil 1: fault clear, low held one second
// [R10] coil 2: halt-on-fault setting
// [R11] discrete 0-31: channel fail results
// [R12] discrete 32: per-shot fail result
// [R13] discrete 33: device error condition
// [R14] regs 4-7: start date and time digits
// [R15] regs 8-9: interval seconds, low half first
// [R16] holding 50004: sampling interval over two
// [R17] only read functions one to four
// [R18] answer only own address, good crc
// [R19] multi reads ascending, no gaps
`timescale 1ns/1ps
module mrs_slave #(
	parameter int HOLD_CYCLES = mrs_pkg::HOLD_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_slave_addr,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	input wire logic i_rx_frame_end,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	output logic o_busy,
	input wire logic i_start,
	input wire logic i_fault_clear,
	input wire logic i_halt_enable,
	input wire logic [31:0] i_chan_fail,
	input wire logic i_fail_result,
	input wire logic i_dev_error,
	input wire logic [31:0] i_total_shots,
	input wire logic [31:0] i_failed_shots,
	input wire logic [31:0] i_date_digits,
	input wire logic [31:0] i_time_digits,
	input wire logic [31:0] i_interval_seconds,
	input wire logic [15:0] i_sample_code
);
	mrs_pkg::mrs_state_t state;
	logic [2:0] pin_meta, pin_sync;
	logic start_held, clear_held, is_exc, req_bits, accept;
	logic [7:0] rx_buf [8];
	logic [7:0] rx_cnt, fn_reg, exc_code, byte_cnt, tx_len, tx_idx, next_tx_byte, next_exc;
	logic [15:0] snap_words [10];
	logic [15:0] snap_hold;
	logic [33:0] snap_bits;
	logic [16:0] start_reg, qty_reg, req_start, req_qty, map_lo, map_cnt, max_qty;

	mrs_crc_if rx_crc();
	mrs_crc_if tx_crc();

	mrs_crc rx_crc_core (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.crc_port(rx_crc)
	);
	mrs_crc tx_crc_core (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.crc_port(tx_crc)
	);

	// ----------------------------------------
	// pin synchronisers and one-second hold
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end else begin
			pin_meta <= {i_halt_enable, i_fault_clear, i_start};
			pin_sync <= pin_meta;
		end
	end

	// [R8] start stretch
	mrs_hold #(.HOLD_CYCLES(HOLD_CYCLES)) start_hold (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_active(pin_sync[0]),
		.o_held(start_held)
	);
	// [R9] clear stretch
	mrs_hold #(.HOLD_CYCLES(HOLD_CYCLES)) clear_hold (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_active(pin_sync[1]),
		.o_held(clear_held)
	);

	// ----------------------------------------
	// request reception
	// ----------------------------------------
	assign accept = (state == mrs_pkg::ST_RX) && i_rx_valid;
	// [R6] running crc
	assign rx_crc.clear = (state != mrs_pkg::ST_RX);
	assign rx_crc.valid = accept;
	assign rx_crc.data = i_rx_data;

	// [R1] request bytes
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_cnt <= 8'h00;
			rx_buf <= '{default: 8'h00};
		end else if (state != mrs_pkg::ST_RX) begin
			rx_cnt <= 8'h00;
		end else if (accept) begin
			if (rx_cnt < mrs_pkg::REQ_LEN) begin
				rx_buf[rx_cnt[2:0]] <= i_rx_data;
			end
			if (rx_cnt != 8'hff) begin
				rx_cnt <= rx_cnt + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// request check
	// ----------------------------------------
	assign req_start = {1'b0, rx_buf[2], rx_buf[3]};
	assign req_qty = {1'b0, rx_buf[4], rx_buf[5]};

	always_comb begin
		req_bits = 1'b0;
		map_lo = 17'h00000;
		map_cnt = 17'h00000;
		next_exc = 8'h00;
		case (rx_buf[1])
			mrs_pkg::FN_COILS: begin
				req_bits = 1'b1;
				map_cnt = mrs_pkg::COIL_COUNT;
			end
			mrs_pkg::FN_DISC: begin
				req_bits = 1'b1;
				map_cnt = mrs_pkg::DISC_COUNT;
			end
			mrs_pkg::FN_HOLD: begin
				map_lo = mrs_pkg::HOLD_BASE;
				map_cnt = mrs_pkg::HOLD_COUNT;
			end
			mrs_pkg::FN_INPUT: map_cnt = mrs_pkg::INPUT_COUNT;
			default: map_cnt = 17'h00000;
		endcase
		max_qty = req_bits ? mrs_pkg::MAX_BITS : mrs_pkg::MAX_REGS;
		// [R17] reads only
		if (map_cnt == 17'h00000) begin
			next_exc = mrs_pkg::EXC_FUNC;
		end else if (rx_cnt != mrs_pkg::REQ_LEN || req_qty == 17'h00000 || req_qty > max_qty) begin
			next_exc = mrs_pkg::EXC_DATA;
		end else if (req_start < map_lo || req_start + req_qty > map_lo + map_cnt) begin
			next_exc = mrs_pkg::EXC_ADDR;
		end
	end

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= mrs_pkg::ST_RX;
			o_busy <= 1'b0;
		end else begin
			o_busy <= (state == mrs_pkg::ST_EVAL) || (state == mrs_pkg::ST_SEND);
			case (state)
				mrs_pkg::ST_RX: begin
					if (i_rx_frame_end) begin
						state <= mrs_pkg::ST_EVAL;
					end
				end
				mrs_pkg::ST_EVAL: begin
					// [R18] silent unless addressed, crc good
					if (rx_cnt >= mrs_pkg::MIN_LEN && rx_crc.crc == 16'h0000
						&& rx_buf[0] == i_slave_addr && rx_buf[0] != mrs_pkg::ADDR_BCAST) begin
						state <= mrs_pkg::ST_SEND;
					end else begin
						state <= mrs_pkg::ST_RX;
					end
				end
				mrs_pkg::ST_SEND: begin
					if (o_tx_valid && i_tx_ready && tx_idx == tx_len - 8'h01) begin
						state <= mrs_pkg::ST_RX;
					end
				end
				default: begin
					state <= mrs_pkg::ST_RX;
				end
			endcase
		end
	end

	// ----------------------------------------
	// answer setup and data snapshot
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fn_reg <= 8'h00;
			start_reg <= 17'h00000;
			qty_reg <= 17'h00000;
			is_exc <= 1'b0;
			exc_code <= 8'h00;
			byte_cnt <= 8'h00;
			tx_len <= 8'h00;
		end else if (state == mrs_pkg::ST_EVAL) begin
			fn_reg <= rx_buf[1];
			start_reg <= req_start - map_lo;
			qty_reg <= req_qty;
			is_exc <= (next_exc != 8'h00);
			exc_code <= next_exc;
			if (next_exc != 8'h00) begin
				tx_len <= mrs_pkg::EXC_LEN;
			end else if (req_bits) begin
				byte_cnt <= 8'((req_qty + 17'h00007) >> 3);
				tx_len <= 8'((req_qty + 17'h00007) >> 3) + mrs_pkg::HDR_LEN + mrs_pkg::CRC_LEN;
			end else begin
				// [R2] two bytes per register
				byte_cnt <= {req_qty[6:0], 1'b0};
				tx_len <= {req_qty[6:0], 1'b0} + mrs_pkg::HDR_LEN + mrs_pkg::CRC_LEN;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			snap_bits <= 34'h0;
			snap_hold <= 16'h0000;
			snap_words <= '{default: 16'h0000};
		end else if (state == mrs_pkg::ST_EVAL) begin
			// [R3] shot counts, low half first
			snap_words[mrs_pkg::REG_TOTAL_SHOTS_LOW] <= i_total_shots[15:0];
			snap_words[mrs_pkg::REG_TOTAL_SHOTS_HIGH] <= i_total_shots[31:16];
			snap_words[mrs_pkg::REG_FAILED_SHOTS_LOW] <= i_failed_shots[15:0];
			snap_words[mrs_pkg::REG_FAILED_SHOTS_HIGH] <= i_failed_shots[31:16];
			// [R14] digits, leading pair first
			snap_words[mrs_pkg::REG_RUN_START_DATE] <= i_date_digits[31:16];
			snap_words[mrs_pkg::REG_RUN_START_DATE + 4'h1] <= i_date_digits[15:0];
			snap_words[mrs_pkg::REG_RUN_START_CLOCK] <= i_time_digits[31:16];
			snap_words[mrs_pkg::REG_RUN_START_CLOCK + 4'h1] <= i_time_digits[15:0];
			// [R15] interval seconds
			snap_words[mrs_pkg::REG_INTERVAL_SECONDS_LOW] <= i_interval_seconds[15:0];
			snap_words[mrs_pkg::REG_INTERVAL_SECONDS_HIGH] <= i_interval_seconds[31:16];
			// [R16] sampling code
			snap_hold <= i_sample_code;
			if (rx_buf[1] == mrs_pkg::FN_COILS) begin
				snap_bits <= 34'h0;
				// [R8] [R9] [R10] coil levels
				snap_bits[mrs_pkg::COIL_START] <= ~start_held;
				snap_bits[mrs_pkg::COIL_CLEAR] <= ~clear_held;
				snap_bits[mrs_pkg::COIL_HALT] <= pin_sync[2];
			end else begin
				// [R11] [R12] [R13] discrete status
				snap_bits <= {i_dev_error, i_fail_result, i_chan_fail};
			end
		end
	end

	// ----------------------------------------
	// answer bytes
	// ----------------------------------------
	function automatic logic [7:0] bit_byte(input logic [33:0] bits, input logic [16:0] first,
		input logic [16:0] qty, input logic [7:0] k);
		logic [7:0] r;
		logic [16:0] pos;
		r = 8'h00;
		for (int j = 0; j < 8; j++) begin
			pos = {6'h00, k[7:0], 3'h0} + 17'(j);
			if (pos < qty && first + pos < mrs_pkg::DISC_COUNT) begin
				r[j] = bits[6'(first + pos)];
			end
		end
		return r;
	endfunction

	always_comb begin
		logic [7:0] k;
		logic [16:0] w;
		logic [15:0] word;
		k = tx_idx - mrs_pkg::HDR_LEN;
		w = start_reg + {10'h000, k[7:1]};
		word = 16'h0000;
		if (fn_reg == mrs_pkg::FN_HOLD) begin
			word = (w == 17'h00000) ? snap_hold : 16'h0000;
		end else if (w < mrs_pkg::INPUT_COUNT) begin
			word = snap_words[4'(w)];
		end
		if (tx_idx == 8'h00) begin
			next_tx_byte = i_slave_addr;
		end else if (tx_idx == 8'h01) begin
			// [R4] flagged function code
			next_tx_byte = is_exc ? (fn_reg | mrs_pkg::EXC_FLAG) : fn_reg;
		end else if (tx_idx == 8'h02) begin
			next_tx_byte = is_exc ? exc_code : byte_cnt;
		end else if (tx_idx == tx_len - 8'h02) begin
			// [R7] low crc byte first
			next_tx_byte = tx_crc.crc[7:0];
		end else if (tx_idx == tx_len - 8'h01) begin
			next_tx_byte = tx_crc.crc[15:8];
		end else if (fn_reg == mrs_pkg::FN_COILS || fn_reg == mrs_pkg::FN_DISC) begin
			next_tx_byte = bit_byte(snap_bits, start_reg, qty_reg, k);
		end else begin
			// [R19] ascending, high byte first
			next_tx_byte = k[0] ? word[7:0] : word[15:8];
		end
	end

	// [R5] crc over sent bytes
	assign tx_crc.clear = (state != mrs_pkg::ST_SEND);
	assign tx_crc.valid = o_tx_valid && i_tx_ready && (tx_idx < tx_len - mrs_pkg::CRC_LEN);
	assign tx_crc.data = o_tx_data;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tx_idx <= 8'h00;
			o_tx_valid <= 1'b0;
			o_tx_data <= 8'h00;
		end else if (state != mrs_pkg::ST_SEND) begin
			tx_idx <= 8'h00;
			o_tx_valid <= 1'b0;
		end else if (!o_tx_valid) begin
			o_tx_data <= next_tx_byte;
			o_tx_valid <= 1'b1;
		end else if (i_tx_ready) begin
			o_tx_valid <= 1'b0;
			tx_idx <= tx_idx + 8'h01;
		end
	end
endmodule

// File: sim/mrs_master.sv
`timescale 1ns/1ps
module mrs_master (
	input wire logic i_clk,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_frame_end,
	output logic o_tx_ready
);
	logic [7:0] got[$];
	bit slow;

	initial begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
		o_frame_end = 1'b0;
		o_tx_ready = 1'b0;
		slow = 1'b0;
	end

	function automatic logic [15:0] crc16(input logic [7:0] m[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (m[i]) begin
			c = c ^ {8'h00, m[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic send(input logic [7:0] m[$], input bit bad);
		logic [15:0] c;
		c = crc16(m) ^ {15'h0000, bad};
		m.push_back(c[7:0]);
		m.push_back(c[15:8]);
		foreach (m[i]) begin
			@(posedge i_clk);
			o_rx_valid <= 1'b1;
			o_rx_data <= m[i];
		end
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~o_rx_data;
		o_frame_end <= 1'b1;
		@(posedge i_clk);
		o_frame_end <= 1'b0;
	endtask

	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx_data);
		o_tx_ready <= slow ? 1'($urandom()) : 1'b1;
	end
endmodule

// File: sim/mrs_slave_chk.sv
`timescale 1ns/1ps
module mrs_slave_chk #(
	parameter int HOLD_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_slave_addr,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	input wire logic i_rx_frame_end,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic o_busy
);
	logic [3:0] nb;
	logic [7:0] first;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// bytes of the current request and its first byte
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			nb <= 4'h0;
		else if (i_rx_frame_end)
			nb <= 4'h0;
		else if (i_rx_valid && !o_busy && nb != 4'hf)
			nb <= nb + 4'h1;
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			first <= 8'h00;
		else if (i_rx_valid && !o_busy && nb == 4'h0)
			first <= i_rx_data;
	end

	sequence s_first;
		$rose(o_tx_valid) && !$past(o_busy, 2);
	endsequence
	sequence s_hs;
		o_tx_valid && i_tx_ready;
	endsequence
	sequence s_next;
		!o_tx_valid ##1 (o_tx_valid || !o_busy);
	endsequence

	a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("byte changed before acceptance");
	a_tx_gap: assert property (s_hs |=> s_next)
		else $error("no idle cycle after a byte");
	a_tx_busy: assert property (o_tx_valid |-> o_busy)
		else $error("byte offered while idle");
	a_ans_lat: assert property (s_first |-> $past(i_rx_frame_end, 3))
		else $error("answer latency wrong");
	a_ans_addr: assert property (s_first |-> o_tx_data == i_slave_addr)
		else $error("answer does not start with own address");
	a_busy_lead: assert property (s_first |-> $past(o_busy))
		else $error("busy did not lead the answer");
	a_silent_addr: assert property (i_rx_frame_end && !o_busy && nb != 4'h0 &&
		first != i_slave_addr |=> !o_tx_valid [*6])
		else $error("answered a foreign address");
	a_silent_short: assert property (i_rx_frame_end && !o_busy && nb < 4'h4
		|=> !o_tx_valid [*6])
		else $error("answered a short frame");
endmodule

// File: sim/tb_serial_read_only_register_slave.sv
`timescale 1ns/1ps
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin fail_count++; \
	$display("unexpected at %0t ns: got %h want %h", $time, g, w); end end
module tb_serial_read_only_register_slave;
	localparam int HOLD = 20;
	logic i_clk, i_arst_n, start, clr, halt, fres, derr, rx_valid, fend, ready, tx_valid, busy;
	logic [7:0] addr, rx_data, tx_data;
	logic [31:0] chan, tot, bad, date, tim, ivl;
	logic [15:0] code;
	logic [7:0] expq[$];
	int fail_count, total_checks;

	mrs_slave #(.HOLD_CYCLES(HOLD)) dut_u (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_slave_addr(addr), .i_rx_data(rx_data),
		.i_rx_valid(rx_valid), .i_rx_frame_end(fend), .o_tx_data(tx_data),
		.o_tx_valid(tx_valid), .i_tx_ready(ready), .o_busy(busy), .i_start(start),
		.i_fault_clear(clr), .i_halt_enable(halt), .i_chan_fail(chan), .i_fail_result(fres),
		.i_dev_error(derr), .i_total_shots(tot), .i_failed_shots(bad), .i_date_digits(date),
		.i_time_digits(tim), .i_interval_seconds(ivl), .i_sample_code(code)
	);
	mrs_master m_u (
		.i_clk(i_clk), .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .o_frame_end(fend), .o_tx_ready(ready)
	);

	// expected answer from the register map
	function automatic void model(input logic [7:0] fn, input int st, n, input bit c0, c1);
		logic [15:0] r[10];
		logic [33:0] b;
		logic [15:0] c;
		int lim, base;
		r = '{tot[15:0], tot[31:16], bad[15:0], bad[31:16], date[31:16], date[15:0],
			tim[31:16], tim[15:0], ivl[15:0], ivl[31:16]};
		b = (fn == 8'h01) ? {31'h0, halt, c1, c0} : {derr, fres, chan};
		lim = (fn == 8'h01) ? 3 : (fn == 8'h02) ? 34 : (fn == 8'h04) ? 10 : 2;
		base = (fn == 8'h03) ? 50004 : 0;
		expq = {addr, fn};
		if (fn < 8'h01 || fn > 8'h04)
			expq = {addr, fn | 8'h80, 8'h01};
		else if (n == 0 || n > (fn < 8'h03 ? 2000 : 125))
			expq = {addr, fn | 8'h80, 8'h03};
		else if (st < base || st + n > base + lim)
			expq = {addr, fn | 8'h80, 8'h02};
		else if (fn < 8'h03) begin
			expq.push_back(8'((n + 7) / 8));
			for (int i = 0; i < (n + 7) / 8; i++) begin
				logic [7:0] v;
				v = 8'h00;
				for (int k = 0; k < 8; k++)
					if (8 * i + k < n)
						v[k] = b[st + 8 * i + k];
				expq.push_back(v);
			end
		end else begin
			expq.push_back(8'(2 * n));
			for (int i = st - base; i < st - base + n; i++) begin
				logic [15:0] v;
				v = (fn == 8'h03) ? (i == 0 ? code : 16'h0000) : r[i];
				expq.push_back(v[15:8]);
				expq.push_back(v[7:0]);
			end
		end
		c = m_u.crc16(expq);
		expq.push_back(c[7:0]);
		expq.push_back(c[15:8]);
	endfunction

	task automatic req(input logic [7:0] fn, input int st, n, input bit c0, c1);
		logic [15:0] s, q;
		s = st[15:0];
		q = n[15:0];
		model(fn, st, n, c0, c1);
		m_u.got = {};
		m_u.send({addr, fn, s[15:8], s[7:0], q[15:8], q[7:0]}, 1'b0);
		repeat (20) @(posedge i_clk);
		for (int t = 0; t < 2000 && busy !== 1'b0; t++)
			@(posedge i_clk);
		`CHK(m_u.got.size(), expq.size())
		foreach (expq[i])
			if (i < m_u.got.size())
				`CHK(m_u.got[i], expq[i])
	endtask

	task automatic quiet(input logic [7:0] m[$], input bit badcrc);
		m_u.got = {};
		m_u.send(m, badcrc);
		repeat (30) @(posedge i_clk);
		`CHK(m_u.got.size(), 0)
	endtask

	task automatic shuffle();
		@(posedge i_clk);
		chan <= $urandom();
		tot <= $urandom();
		bad <= $urandom();
		date <= $urandom();
		tim <= $urandom();
		ivl <= $urandom();
		code <= 16'($urandom());
		fres <= 1'($urandom());
		derr <= 1'($urandom());
		halt <= 1'($urandom());
		addr <= 8'($urandom_range(1, 31));
		m_u.slow = 1'($urandom());
		repeat (3) @(posedge i_clk);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	initial begin
		repeat (60000) @(posedge i_clk);
		fail_count++;
		close_out();
	end

	initial begin
		static int tf[12] = '{1, 2, 2, 4, 4, 3, 5, 7, 4, 4, 1, 3};
		static int ts[12] = '{0, 0, 30, 0, 9, 50004, 0, 0, 9, 0, 0, 50003};
		static int tn[12] = '{3, 34, 4, 10, 1, 2, 1, 1, 2, 0, 2001, 2};
		logic [7:0] fn;
		int lim, n, st;
		{start, clr, halt, fres, derr, chan, tot, bad, date, tim, ivl, code} = '0;
		addr = 8'h11;
		i_arst_n = 1'b0;
		void'($urandom(32'h9985ebe0));
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		`CHK(m_u.crc16({8'h01, 8'h03, 8'h00, 8'h08, 8'h00, 8'h01}), 16'hc805)
		// every function, edges of the map
		foreach (tf[i]) begin
			shuffle();
			req(8'(tf[i]), ts[i], tn[i], 1'b1, 1'b1);
		end
		$display("map test done");
		quiet({addr + 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
		quiet({addr, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
		quiet({8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
		quiet({addr}, 1'b0);
		$display("silent test done");
		// start and clear held low, one at a time
		for (int p = 0; p < 2; p++) begin
			@(posedge i_clk);
			start <= (p == 0);
			clr <= (p == 1);
			repeat (4) @(posedge i_clk);
			start <= 1'b0;
			clr <= 1'b0;
			req(8'h01, 0, 3, p != 0, p != 1);
			repeat (HOLD + 40) @(posedge i_clk);
			req(8'h01, 0, 3, 1'b1, 1'b1);
		end
		$display("hold test done");
		for (int j = 0; j < 24; j++) begin
			shuffle();
			fn = 8'($urandom_range(1, 4));
			lim = (fn == 8'h01) ? 3 : (fn == 8'h02) ? 34 : (fn == 8'h04) ? 10 : 2;
			n = $urandom_range(1, lim);
			st = (fn == 8'h03 ? 50004 : 0) + $urandom_range(0, lim - n);
			req(fn, st, n, 1'b1, 1'b1);
		end
		$display("random test done");
		close_out();
	end
endmodule

bind mrs_slave mrs_slave_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_slave_addr(i_slave_addr), .i_rx_data(i_rx_data),
	.i_rx_valid(i_rx_valid), .i_rx_frame_end(i_rx_frame_end), .o_tx_data(o_tx_data),
	.o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready), .o_busy(o_busy)
);
